// ===== uart_match_and_autobaud_snap.sv
// Contract
// - With matching on, hit on match char four or five sets match flag.
// - With address-bit handling on, the address bit must also equal compare bit.
// - With matching off, chars four and five never set the match flag.
// - Four autobaud registers: divisor high byte, threshold low byte, reset zero.
// - Calculated divisor at or below threshold zero selects valid divisor zero.
// - Above threshold zero, at or below threshold one, selects divisor one.
// - Above threshold one, at or below threshold two, selects divisor two.
// - Above threshold two, at or below threshold three, selects divisor three.
// - Above threshold three the calculated divisor is used unchanged.
// - With autobaud on, the rate divisor field loads detected or snapped value.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "uart_snap_defs.svh"

module uart_match_and_autobaud_snap
   import uart_snap_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`APB_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Receiver character stream
   input wire logic rx_char_valid,
   input wire rx_char_s rx_char,
   // Autobaud measurement
   input wire logic calc_valid,
   input wire logic [15:0] calc_divisor,
   // Results
   output logic [15:0] rate_divisor,
   output logic rate_load,
   output logic match_flag,
   output logic irq
);

   logic [1:0] rst_sync_reg;
   logic rst_n;
   logic [15:0] match_chars_upper_pair_reg;
   autobaud_set_t pair_reg;
   logic [15:0] fast_port_control_zero_reg;
   logic [15:0] fast_port_control_one_reg;
   logic [`ST_WIDTH-1:0] fast_port_status_reg;
   logic [`ST_WIDTH-1:0] status_next;
   logic [`ST_WIDTH-1:0] int_enable_reg;
   logic [15:0] rate_divisor_reg;
   logic rate_load_reg;
   logic irq_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic [`REG_IDX_W-1:0] reg_idx;
   logic wr_fire;
   logic rd_hit;
   logic [15:0] rd_word;
   logic char_compare_enable;
   logic addr_bit_enable;
   logic auto_rate_enable;
   logic compare_addr_bit_two;
   logic [1:0] slot_hit;
   logic match_event;
   logic load_event;
   logic [15:0] chosen_divisor;
   logic substituted;
   logic [`ST_WIDTH-1:0] clear_bits;

   // Reset release is synchronised; assertion stays asynchronous.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   assign char_compare_enable = fast_port_control_one_reg[`CTRL1_CMP_EN];
   assign auto_rate_enable = fast_port_control_one_reg[`CTRL1_AUTO_RATE_EN];
   assign compare_addr_bit_two =
      fast_port_control_one_reg[`CTRL1_CMP_ADDR_BIT2];
   assign addr_bit_enable = fast_port_control_zero_reg[`CTRL0_ADDR_BIT_EN];

   // APB: one wait state, so read data leaves a flip-flop.
   assign reg_idx = paddr[`APB_ADDR_W-1:2];
   assign wr_fire = psel & penable & pready_reg & pwrite;

   always_comb begin
      rd_hit = 1'b1;
      rd_word = `RST_WORD16;
      case (reg_idx)
         `IDX_RATE_DIVISOR: rd_word = rate_divisor_reg;
         `IDX_MATCH_UPPER: rd_word = match_chars_upper_pair_reg;
         `IDX_AB_PAIR_ZERO: rd_word = pair_reg[0];
         `IDX_AB_PAIR_ONE: rd_word = pair_reg[1];
         `IDX_AB_PAIR_TWO: rd_word = pair_reg[2];
         `IDX_AB_PAIR_THREE: rd_word = pair_reg[3];
         `IDX_CONTROL_ZERO: rd_word = fast_port_control_zero_reg;
         `IDX_CONTROL_ONE: rd_word = fast_port_control_one_reg;
         `IDX_STATUS: rd_word = {14'h0, fast_port_status_reg};
         `IDX_INT_ENABLE: rd_word = {14'h0, int_enable_reg};
         // The clear register is write-only and reads as zero.
         `IDX_INT_CLEAR: rd_word = `RST_WORD16;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else if (psel && penable && !pready_reg) begin
         pready_reg <= 1'b1;
         pslverr_reg <= ~rd_hit;
         prdata_reg <= (pwrite || !rd_hit) ? 32'h0000_0000
                                           : {16'h0000, rd_word};
      end else begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end
   end

   // Software-owned configuration registers.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         match_chars_upper_pair_reg <= `RST_WORD16;
         fast_port_control_zero_reg <= `RST_WORD16;
         fast_port_control_one_reg <= `RST_WORD16;
         int_enable_reg <= `RST_STATUS;
      end else if (wr_fire) begin
         case (reg_idx)
            `IDX_MATCH_UPPER: match_chars_upper_pair_reg <= pwdata[15:0];
            `IDX_CONTROL_ZERO: fast_port_control_zero_reg <= pwdata[15:0];
            `IDX_CONTROL_ONE: fast_port_control_one_reg <= pwdata[15:0];
            `IDX_INT_ENABLE: int_enable_reg <= pwdata[`ST_WIDTH-1:0];
            default: ;
         endcase
      end
   end

   // Autobaud pairs are not locked while autobaud runs; keeping them still
   // then is software's duty, and a change only alters the next snap.
   genvar gp;
   generate
      for (gp = 0; gp < 4; gp++) begin : g_pair
         always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               pair_reg[gp] <= `RST_WORD16;
            end else if (wr_fire &&
                         reg_idx == `IDX_AB_PAIR_ZERO + 10'(2 * gp)) begin
               pair_reg[gp] <= pwdata[15:0];
            end
         end
      end
   endgenerate

   // Character matching against the upper pair.
   genvar gs;
   generate
      for (gs = 0; gs < 2; gs++) begin : g_slot
         logic [7:0] match_char;
         assign match_char = (gs == 0)
            ? match_chars_upper_pair_reg[`CHAR_LOW_LSB +: 8]
            : match_chars_upper_pair_reg[`CHAR_HIGH_LSB +: 8];
         assign slot_hit[gs] = (rx_char.data == match_char) &&
            (!addr_bit_enable ||
             rx_char.addr_bit == compare_addr_bit_two);
      end
   endgenerate

   assign match_event = rx_char_valid && char_compare_enable &&
                        (|slot_hit);

   // Divisor snapping.
   snap_divisor_select u_select (
      .calc_divisor(calc_divisor),
      .pairs(pair_reg),
      .chosen_divisor(chosen_divisor),
      .substituted(substituted)
   );

   assign load_event = calc_valid && auto_rate_enable;

   // Hardware load wins over a software write landing in the same cycle.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rate_divisor_reg <= `RST_WORD16;
      end else if (load_event) begin
         rate_divisor_reg <= chosen_divisor;
      end else if (wr_fire && reg_idx == `IDX_RATE_DIVISOR) begin
         rate_divisor_reg <= pwdata[15:0];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rate_load_reg <= 1'b0;
      end else begin
         rate_load_reg <= load_event;
      end
   end

   // Sticky status: a set in the clearing cycle survives the clear.
   assign clear_bits = (wr_fire && reg_idx == `IDX_INT_CLEAR)
                       ? pwdata[`ST_WIDTH-1:0] : `RST_STATUS;

   always_comb begin
      status_next = fast_port_status_reg & ~clear_bits;
      if (match_event) begin
         status_next[`ST_MATCH] = 1'b1;
      end
      if (load_event) begin
         status_next[`ST_DIV_LOAD] = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fast_port_status_reg <= `RST_STATUS;
         irq_reg <= 1'b0;
      end else begin
         fast_port_status_reg <= status_next;
         irq_reg <= |(status_next & int_enable_reg);
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign rate_divisor = rate_divisor_reg;
   assign rate_load = rate_load_reg;
   assign match_flag = fast_port_status_reg[`ST_MATCH];
   assign irq = irq_reg;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   a_match_sets_flag: assert property (
      rx_char_valid && char_compare_enable &&
      rx_char.data == match_chars_upper_pair_reg[15:8] && !addr_bit_enable
      |=> match_flag)
      else $error("match on char five did not set the flag");

   a_addr_bit_blocks: assert property (
      rx_char_valid && addr_bit_enable &&
      rx_char.addr_bit != compare_addr_bit_two && !calc_valid &&
      !fast_port_status_reg[`ST_MATCH] && clear_bits == `RST_STATUS
      |=> !match_flag)
      else $error("flag set despite address bit mismatch");

   a_disabled_no_match: assert property (
      !char_compare_enable && !match_flag |=> !match_flag)
      else $error("flag set while matching disabled");

   a_pair_reset_zero: assert property (
      $rose(rst_n) |-> pair_reg == 64'h0)
      else $error("autobaud pairs not zero after reset");

   a_window_zero: assert property (
      load_event && calc_divisor <= {8'h00, pair_reg[0].threshold}
      |=> rate_divisor == {8'h00, $past(pair_reg[0].valid_divisor)})
      else $error("window zero did not pick divisor zero");

   a_window_one: assert property (
      load_event && calc_divisor > {8'h00, pair_reg[0].threshold} &&
      calc_divisor <= {8'h00, pair_reg[1].threshold}
      |=> rate_divisor == {8'h00, $past(pair_reg[1].valid_divisor)})
      else $error("window one did not pick divisor one");

   a_window_two: assert property (
      load_event && calc_divisor > {8'h00, pair_reg[1].threshold} &&
      calc_divisor <= {8'h00, pair_reg[2].threshold} &&
      calc_divisor > {8'h00, pair_reg[0].threshold}
      |=> rate_divisor == {8'h00, $past(pair_reg[2].valid_divisor)})
      else $error("window two did not pick divisor two");

   a_window_three: assert property (
      load_event && calc_divisor > {8'h00, pair_reg[2].threshold} &&
      calc_divisor > {8'h00, pair_reg[1].threshold} &&
      calc_divisor > {8'h00, pair_reg[0].threshold} &&
      calc_divisor <= {8'h00, pair_reg[3].threshold}
      |=> rate_divisor == {8'h00, $past(pair_reg[3].valid_divisor)})
      else $error("window three did not pick divisor three");

   a_pass_through: assert property (
      load_event && (calc_divisor[15:8] != 8'h00 ||
      pair_reg[3].threshold == 8'h00 && calc_divisor != 16'h0000)
      |=> rate_divisor == $past(calc_divisor) && rate_load)
      else $error("large divisor was not passed unchanged");

   a_load_only_enabled: assert property (
      rate_load |-> $past(auto_rate_enable) && $past(calc_valid))
      else $error("divisor load without autobaud enabled");

   a_no_load_disabled: assert property (
      !auto_rate_enable |=> !rate_load)
      else $error("rate load pulsed with autobaud disabled");

   a_load_sets_status: assert property (
      load_event |=> rate_load && fast_port_status_reg[`ST_DIV_LOAD])
      else $error("autobaud load did not pulse or set status");

   a_char_four_flag: assert property (
      rx_char_valid && char_compare_enable && !addr_bit_enable &&
      rx_char.data == match_chars_upper_pair_reg[`CHAR_LOW_LSB +: 8]
      |=> match_flag)
      else $error("match on char four did not set the flag");

   a_addr_bit_passes: assert property (
      rx_char_valid && char_compare_enable && addr_bit_enable &&
      rx_char.addr_bit == compare_addr_bit_two &&
      rx_char.data == match_chars_upper_pair_reg[`CHAR_HIGH_LSB +: 8]
      |=> match_flag)
      else $error("matching address bit did not set the flag");

   a_pair_write_lands: assert property (
      wr_fire && reg_idx == `IDX_AB_PAIR_THREE
      |=> pair_reg[3] == $past(pwdata[15:0]))
      else $error("autobaud pair write did not land");

   a_ready_after_access: assert property (
      psel && penable && !pready |=> pready)
      else $error("bus ready did not follow the first access cycle");

   a_irq_tracks_status: assert property (
      irq == |(fast_port_status_reg & $past(int_enable_reg)))
      else $error("interrupt does not follow enabled status");

   c_match_hit: cover property (match_event ##1 match_flag);
   c_snapped_load: cover property (load_event && substituted ##1 rate_load);
   c_raw_load: cover property (load_event && !substituted ##1 rate_load);
   c_irq_raised: cover property ($rose(irq));
   c_addr_bit_hit: cover property (match_event && addr_bit_enable);

endmodule

// ===== uart_snap_defs.svh
`ifndef UART_SNAP_DEFS_SVH
`define UART_SNAP_DEFS_SVH

// APB address width in bits and register index width.
`define APB_ADDR_W 12
`define REG_IDX_W 10

// Register indices; the byte address is four times the index.
`define IDX_RATE_DIVISOR 10'h26e
`define IDX_MATCH_UPPER 10'h274
`define IDX_AB_PAIR_ZERO 10'h276
`define IDX_AB_PAIR_ONE 10'h278
`define IDX_AB_PAIR_TWO 10'h27a
`define IDX_AB_PAIR_THREE 10'h27c
`define IDX_CONTROL_ZERO 10'h290
`define IDX_CONTROL_ONE 10'h292
`define IDX_STATUS 10'h294
`define IDX_INT_ENABLE 10'h296
`define IDX_INT_CLEAR 10'h298

// Reset values.
`define RST_WORD16 16'h0000
`define RST_STATUS 2'h0

// Field positions.
`define CHAR_LOW_LSB 0
`define CHAR_HIGH_LSB 8
`define CTRL0_ADDR_BIT_EN 2
`define CTRL1_CMP_EN 0
`define CTRL1_AUTO_RATE_EN 1
`define CTRL1_CMP_ADDR_BIT2 2
`define ST_MATCH 0
`define ST_DIV_LOAD 1
`define ST_WIDTH 2

`endif

// ===== uart_snap_pkg.sv
package uart_snap_pkg;

   // One autobaud register: valid divisor in the high byte.
   typedef struct packed {
      logic [7:0] valid_divisor;
      logic [7:0] threshold;
   } autobaud_pair_s;

   // One received character with its address bit.
   typedef struct packed {
      logic addr_bit;
      logic [7:0] data;
   } rx_char_s;

   typedef autobaud_pair_s [3:0] autobaud_set_t;

endpackage

// ===== snap_divisor_select.sv
`timescale 1ns/1ps
`include "uart_snap_defs.svh"

module snap_divisor_select
   import uart_snap_pkg::*;
(
   // Measured divisor and programmed windows
   input wire logic [15:0] calc_divisor,
   input wire autobaud_set_t pairs,
   // Divisor to load
   output logic [15:0] chosen_divisor,
   output logic substituted
);

   logic [3:0] at_or_below;

   // Thresholds are zero-extended so a wide divisor never lands in a window.
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_win
         assign at_or_below[gi] =
            calc_divisor <= {8'h00, pairs[gi].threshold};
      end
   endgenerate

   // The lowest window that holds the divisor wins; windows above it also
   // hold it, so scanning downward gives the first match last.
   always_comb begin
      chosen_divisor = calc_divisor;
      substituted = 1'b0;
      for (int i = 3; i >= 0; i--) begin
         if (at_or_below[i]) begin
            chosen_divisor = {8'h00, pairs[i].valid_divisor};
            substituted = 1'b1;
         end
      end
   end

endmodule

// ===== rx_source.sv
`timescale 1ns/1ps

module rx_source
   import uart_snap_pkg::*;
(
   // Clock
   input wire logic clock,
   // Characters and autobaud measurement toward the block
   output logic rx_char_valid,
   output rx_char_s rx_char,
   output logic calc_valid,
   output logic [15:0] calc_divisor
);
   // Data lines show the inverse of the last value between pulses, so a
   // design that samples them outside the pulse cannot pass by luck.
   initial begin
      rx_char_valid = 1'b0;
      rx_char = 9'h1ff;
      calc_valid = 1'b0;
      calc_divisor = 16'hffff;
   end

   task automatic send_char(input logic ab, input logic [7:0] d,
                            input int gap);
      repeat (gap) @(posedge clock);
      @(posedge clock);
      rx_char_valid <= 1'b1;
      rx_char <= {ab, d};
      @(posedge clock);
      rx_char_valid <= 1'b0;
      rx_char <= ~{ab, d};
   endtask

   task automatic send_calc(input logic [15:0] d, input int gap);
      repeat (gap) @(posedge clock);
      @(posedge clock);
      calc_valid <= 1'b1;
      calc_divisor <= d;
      @(posedge clock);
      calc_valid <= 1'b0;
      calc_divisor <= ~d;
   endtask
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
`include "uart_snap_defs.svh"

module tb_top
   import uart_snap_pkg::*;
;
   logic clock;
   logic resetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic rx_char_valid;
   rx_char_s rx_char;
   logic calc_valid;
   logic [15:0] calc_divisor;
   logic [15:0] rate_divisor;
   logic rate_load;
   logic match_flag;
   logic irq;
   int num_errors = 0;
   int samples_checked = 0;
   logic [15:0] ab_tab [0:3] = '{16'h1020, 16'h3040, 16'h5060, 16'h7080};
   logic [15:0] calc_tab [0:12] = '{16'h0000, 16'h0001, 16'h0020,
      16'h0021, 16'h0040, 16'h0041, 16'h0060, 16'h0061, 16'h0080,
      16'h0081, 16'h00ff, 16'h0100, 16'hffff};
   logic [15:0] exp_tab [0:12] = '{16'h0010, 16'h0010, 16'h0010,
      16'h0030, 16'h0030, 16'h0050, 16'h0050, 16'h0070, 16'h0070,
      16'h0081, 16'h00ff, 16'h0100, 16'hffff};

   uart_match_and_autobaud_snap i_dut (
      .clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_char_valid(rx_char_valid),
      .rx_char(rx_char), .calc_valid(calc_valid),
      .calc_divisor(calc_divisor), .rate_divisor(rate_divisor),
      .rate_load(rate_load), .match_flag(match_flag), .irq(irq)
   );

   rx_source i_src (
      .clock(clock), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
      .calc_valid(calc_valid), .calc_divisor(calc_divisor)
   );

   initial clock = 1'b0;
   always #2 clock = ~clock;

   task automatic stop_test();
      if (num_errors == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string what);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what,
                  got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [9:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) check(1'b0, 1'b1, "pready never came");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
      logic [31:0] rd;
      logic err;
      apb(1'b1, idx, wd, rd, err);
   endtask

   task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp,
                         input logic exp_err);
      logic [31:0] rd;
      logic err;
      apb(1'b0, idx, 32'h0, rd, err);
      check(rd, exp, "read data");
      check({31'h0, err}, {31'h0, exp_err}, "slave error");
   endtask

   // Sends one character, checks flag, interrupt and status, then clears.
   task automatic char_chk(input logic ab, input logic [7:0] d,
                           input logic exp_flag, input logic exp_irq);
      i_src.send_char(ab, d, 0);
      #1;
      check({31'h0, match_flag}, {31'h0, exp_flag}, "match flag");
      check({31'h0, irq}, {31'h0, exp_irq}, "interrupt");
      rd_chk(`IDX_STATUS, {31'h0, exp_flag}, 1'b0);
      wr(`IDX_INT_CLEAR, 32'h1);
   endtask

   task automatic abd_chk(input logic [15:0] c, input logic [15:0] exp,
                          input int gap);
      i_src.send_calc(c, gap);
      #1;
      check({31'h0, rate_load}, 32'h1, "rate load");
      check({16'h0, rate_divisor}, {16'h0, exp}, "rate divisor");
   endtask

   initial begin
      #100000;
      check(1'b0, 1'b1, "watchdog expired");
      stop_test();
   end

   initial begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      repeat (3) @(posedge clock);
      for (int i = 0; i < 4; i++) begin
         rd_chk(`IDX_AB_PAIR_ZERO + 10'(2 * i), 32'h0, 1'b0);
      end
      rd_chk(`IDX_MATCH_UPPER, 32'h0, 1'b0);
      rd_chk(`IDX_STATUS, 32'h0, 1'b0);
      rd_chk(10'h001, 32'h0, 1'b1);
      // Ascending interleaved pairs, highest in the last register.
      for (int i = 0; i < 4; i++) begin
         wr(`IDX_AB_PAIR_ZERO + 10'(2 * i), {16'hffff, ab_tab[i]});
         rd_chk(`IDX_AB_PAIR_ZERO + 10'(2 * i), {16'h0, ab_tab[i]}, 1'b0);
      end
      wr(`IDX_INT_ENABLE, 32'h1);
      wr(`IDX_CONTROL_ONE, 32'h1);
      char_chk(1'b0, 8'h00, 1'b1, 1'b1);
      wr(`IDX_MATCH_UPPER, 32'h5a13);
      char_chk(1'b0, 8'h13, 1'b1, 1'b1);
      char_chk(1'b0, 8'h5a, 1'b1, 1'b1);
      char_chk(1'b0, 8'h77, 1'b0, 1'b0);
      wr(`IDX_INT_ENABLE, 32'h0);
      char_chk(1'b0, 8'h13, 1'b1, 1'b0);
      wr(`IDX_INT_ENABLE, 32'h1);
      wr(`IDX_CONTROL_ONE, 32'h0);
      char_chk(1'b0, 8'h13, 1'b0, 1'b0);
      char_chk(1'b0, 8'h5a, 1'b0, 1'b0);
      wr(`IDX_CONTROL_ZERO, 32'h4);
      wr(`IDX_CONTROL_ONE, 32'h5);
      char_chk(1'b0, 8'h13, 1'b0, 1'b0);
      char_chk(1'b1, 8'h13, 1'b1, 1'b1);
      char_chk(1'b1, 8'h5a, 1'b1, 1'b1);
      wr(`IDX_CONTROL_ONE, 32'h1);
      char_chk(1'b1, 8'h5a, 1'b0, 1'b0);
      char_chk(1'b0, 8'h5a, 1'b1, 1'b1);
      wr(`IDX_CONTROL_ZERO, 32'h0);
      wr(`IDX_CONTROL_ONE, 32'h0);
      i_src.send_calc(16'h0030, 0);
      #1;
      check({31'h0, rate_load}, 32'h0, "load while disabled");
      check({16'h0, rate_divisor}, 32'h0, "divisor while disabled");
      wr(`IDX_CONTROL_ONE, 32'h2);
      for (int i = 0; i < 13; i++) begin
         abd_chk(calc_tab[i], exp_tab[i], i % 3);
      end
      rd_chk(`IDX_STATUS, 32'h2, 1'b0);
      rd_chk(`IDX_RATE_DIVISOR, 32'hffff, 1'b0);
      wr(`IDX_CONTROL_ONE, 32'h0);
      for (int i = 0; i < 4; i++) begin
         wr(`IDX_AB_PAIR_ZERO + 10'(2 * i), 32'h0);
      end
      wr(`IDX_CONTROL_ONE, 32'h2);
      abd_chk(16'h0005, 16'h0005, 0);
      abd_chk(16'h0000, 16'h0000, 1);
      wr(`IDX_CONTROL_ONE, 32'h0);
      wr(`IDX_RATE_DIVISOR, 32'h0123);
      rd_chk(`IDX_RATE_DIVISOR, 32'h0123, 1'b0);
      wr(`IDX_INT_CLEAR, 32'h2);
      rd_chk(`IDX_STATUS, 32'h0, 1'b0);
      rd_chk(`IDX_INT_CLEAR, 32'h0, 1'b0);
      stop_test();
   end
endmodule
